// File: rtl/meb_master.v
/*
  Strobe sequencer of a multiplexed address/data expansion bus master.
  Assumes synchronous inputs, a requester that holds start_in until busy_out
  rises, and a peripheral that drives ad_in while read_strobe_n_out is low.
*/
// Operation
// - Latch strobe high 1 to 4 bus cycles, address already valid.
// - Address stays on shared lines exactly one cycle after latch strobe falls.
// - Address phase setting sets how long the address is presented.
// - Chip select valid 1 to 4 cycles after latch strobe falls.
// - Write data valid 1 to 4 cycles before write strobe falls.
// - Write strobe low for 1 to 16 bus cycles.
// - Strobe phase setting sets strobe width; data valid throughout.
// - Write data held 1 to 4 cycles after write strobe rises.
// - Hold setting keeps chip select and write data after strobe.
// - Recovery gap of 1 to 16 cycles between accesses.
// - Every phase counted in expansion bus clock periods.
`timescale 1ns/100ps
`include "meb_consts.vh"

module meb_master #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16,
  parameter [`MEB_DIV_W-1:0] BUS_DIV = `MEB_BUS_DIV
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire write_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire [DATA_W-1:0] wdata_in,
  input wire [`MEB_SHORT_LEN_W-1:0] address_phase_len_in,
  input wire [`MEB_SHORT_LEN_W-1:0] cs_delay_len_in,
  input wire [`MEB_SHORT_LEN_W-1:0] data_setup_phase_len_in,
  input wire [`MEB_LONG_LEN_W-1:0] strobe_phase_len_in,
  input wire [`MEB_SHORT_LEN_W-1:0] hold_phase_len_in,
  input wire [`MEB_LONG_LEN_W-1:0] recovery_phase_len_in,
  input wire [ADDR_W-1:0] ad_in,
  output reg [ADDR_W-1:0] ad_out,
  output reg ad_oe_out,
  output reg address_latch_strobe_out,
  output reg chip_select_n_out,
  output reg write_strobe_n_out,
  output reg read_strobe_n_out,
  output reg bus_tick_out,
  output reg busy_out,
  output reg done_out,
  output reg [DATA_W-1:0] rdata_out
);

  localparam ST_IDLE = `MEB_ST_IDLE;
  localparam ST_ALE = `MEB_ST_ALE;
  localparam ST_AHOLD = `MEB_ST_AHOLD;
  localparam ST_SETUP = `MEB_ST_SETUP;
  localparam ST_STROBE = `MEB_ST_STROBE;
  localparam ST_HOLD = `MEB_ST_HOLD;
  localparam ST_RECOV = `MEB_ST_RECOV;

  reg [`MEB_ST_W-1:0] state_r;
  reg [`MEB_ST_W-1:0] state_nxt;
  reg [`MEB_DIV_W-1:0] div_r;
  reg bus_en_r;
  reg pend_r;
  reg wr_r;
  reg [ADDR_W-1:0] addr_r;
  reg [DATA_W-1:0] wdata_r;
  reg [2:0] cs_left_r;
  reg pc_load;
  reg [`MEB_CNT_W-1:0] pc_len;
  wire phase_last;
  wire advance;

  //////////////////////////////////////////////////////////////////////////////
  // Bus clock enable
  // A divider rather than a second clock keeps every phase in one domain
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
      bus_en_r <= 1'b0;
    end else if (div_r >= BUS_DIV - 8'h01) begin
      div_r <= 8'h00;
      bus_en_r <= 1'b1;
    end else begin
      div_r <= div_r + 8'h01;
      bus_en_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase timer
  meb_phase_cnt u_phase_cnt (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(bus_en_r),
    .load_in(pc_load),
    .len_m1_in(pc_len),
    .last_out(phase_last)
  );

  // Strobe may not start before chip select is active
  assign advance = bus_en_r && phase_last && (state_r != ST_SETUP || !chip_select_n_out);

  //////////////////////////////////////////////////////////////////////////////
  // Phase order
  always @* begin
    state_nxt = state_r;
    pc_load = 1'b0;
    pc_len = `MEB_CNT_RST;
    case (state_r)
      ST_IDLE: begin
        if (bus_en_r && pend_r) begin
          state_nxt = ST_ALE;
          pc_load = 1'b1;
          pc_len = {2'b00, address_phase_len_in};
        end
      end
      ST_ALE: begin
        if (advance) begin
          state_nxt = ST_AHOLD;
          pc_load = 1'b1;
          pc_len = `MEB_ADDR_HOLD_M1;
        end
      end
      ST_AHOLD: begin
        if (advance) begin
          state_nxt = ST_SETUP;
          pc_load = 1'b1;
          pc_len = {2'b00, data_setup_phase_len_in};
        end
      end
      ST_SETUP: begin
        if (advance) begin
          state_nxt = ST_STROBE;
          pc_load = 1'b1;
          pc_len = strobe_phase_len_in;
        end
      end
      ST_STROBE: begin
        if (advance) begin
          state_nxt = ST_HOLD;
          pc_load = 1'b1;
          pc_len = {2'b00, hold_phase_len_in};
        end
      end
      ST_HOLD: begin
        if (advance) begin
          state_nxt = ST_RECOV;
          pc_load = 1'b1;
          pc_len = recovery_phase_len_in;
        end
      end
      ST_RECOV: begin
        if (advance) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State, request capture and pins
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= {ADDR_W{1'b0}};
      wdata_r <= {DATA_W{1'b0}};
      cs_left_r <= `MEB_CS_RST;
      ad_out <= {ADDR_W{1'b0}};
      ad_oe_out <= 1'b0;
      address_latch_strobe_out <= 1'b0;
      chip_select_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      bus_tick_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= {DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      bus_tick_out <= bus_en_r;
      done_out <= 1'b0;
      if (!busy_out && start_in) begin
        pend_r <= 1'b1;
        busy_out <= 1'b1;
        wr_r <= write_in;
        addr_r <= addr_in;
        wdata_r <= wdata_in;
      end
      if (bus_en_r) begin
        // Chip select delay from latch fall
        if (cs_left_r != 3'h0) begin
          cs_left_r <= cs_left_r - 3'h1;
          if (cs_left_r == 3'h1) begin
            chip_select_n_out <= 1'b0;
          end
        end
      end
      case (state_nxt)
        ST_ALE: begin
          pend_r <= 1'b0;
          address_latch_strobe_out <= 1'b1;
          ad_out <= addr_r;
          ad_oe_out <= 1'b1;
        end
        ST_AHOLD: begin
          address_latch_strobe_out <= 1'b0;
          if (state_r == ST_ALE) begin
            cs_left_r <= {1'b0, cs_delay_len_in} + 3'h1;
          end
        end
        ST_SETUP: begin
          ad_out <= wr_r ? wdata_r[ADDR_W-1:0] : addr_r;
          ad_oe_out <= wr_r;
        end
        ST_STROBE: begin
          write_strobe_n_out <= !wr_r;
          read_strobe_n_out <= wr_r;
        end
        ST_HOLD: begin
          write_strobe_n_out <= 1'b1;
          read_strobe_n_out <= 1'b1;
          // Taken only as the strobe ends, so rdata_out never shows half-driven lines
          if (state_r == ST_STROBE && !wr_r) begin
            rdata_out <= ad_in[DATA_W-1:0];
          end
        end
        ST_RECOV: begin
          chip_select_n_out <= 1'b1;
          cs_left_r <= `MEB_CS_RST;
          ad_oe_out <= 1'b0;
        end
        ST_IDLE: begin
          if (state_r == ST_RECOV) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default: begin
          ad_oe_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // meb_master

// File: rtl/meb_phase_cnt.v
/*
  Down counter that times one bus phase in bus cycles.
  Assumes tick_in is the one-cycle bus clock enable and load_in is only
  raised together with tick_in.
*/
`timescale 1ns/100ps
`include "meb_consts.vh"

module meb_phase_cnt (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire tick_in,
  input wire load_in,
  input wire [`MEB_CNT_W-1:0] len_m1_in,
  output wire last_out
);

  reg [`MEB_CNT_W-1:0] cnt_r;

  // Zero means the current bus cycle is the phase's last one
  assign last_out = (cnt_r == `MEB_CNT_RST);

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= `MEB_CNT_RST;
    end else if (load_in) begin
      cnt_r <= len_m1_in;
    end else if (tick_in && !last_out) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

endmodule // meb_phase_cnt

// File: shared/meb_consts.vh
/*
  Constants of the multiplexed expansion bus master: state codes, phase length
  field widths, fixed address hold and reset values.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef MEB_CONSTS_VH
`define MEB_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// One-hot states
`define MEB_ST_W 7
`define MEB_ST_IDLE 7'h01
`define MEB_ST_ALE 7'h02
`define MEB_ST_AHOLD 7'h04
`define MEB_ST_SETUP 7'h08
`define MEB_ST_STROBE 7'h10
`define MEB_ST_HOLD 7'h20
`define MEB_ST_RECOV 7'h40

////////////////////////////////////////////////////////////////////////////////
// Phase length fields hold length minus one
`define MEB_SHORT_LEN_W 2
`define MEB_LONG_LEN_W 4
`define MEB_CNT_W 4
// Address hold after latch strobe fall, fixed, minus one
`define MEB_ADDR_HOLD_M1 4'h0
// Default bus clock divider (system cycles per bus cycle)
`define MEB_BUS_DIV 4
`define MEB_DIV_W 8

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MEB_CNT_RST 4'h0
`define MEB_CS_RST 3'h0

`endif

// File: sim/meb_master_monitor.sv
/* Port checker for meb_master.
   Assumes one clock and a bus divider of at least 2. */
`timescale 1ns/100ps
module meb_master_chk (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire start_in,
  input wire busy_out,
  input wire done_out,
  input wire ad_oe_out,
  input wire address_latch_strobe_out,
  input wire chip_select_n_out,
  input wire write_strobe_n_out,
  input wire read_strobe_n_out,
  input wire bus_tick_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ale_min_len: assert property ($rose(address_latch_strobe_out) |-> address_latch_strobe_out[*2])
    else $error("latch strobe too short");
  a_ahold_no_cs: assert property ($fell(address_latch_strobe_out) |-> (chip_select_n_out && ad_oe_out)[*2])
    else $error("address hold broken");
  a_cs_first: assert property (!write_strobe_n_out || !read_strobe_n_out |-> !chip_select_n_out)
    else $error("strobe without chip select");
  a_wr_drive: assert property (!write_strobe_n_out |-> ad_oe_out && read_strobe_n_out)
    else $error("write strobe without data");
  a_rd_float: assert property (!read_strobe_n_out |-> !ad_oe_out)
    else $error("lines driven during read");
  a_wr_hold: assert property ($rose(write_strobe_n_out) |-> (ad_oe_out && !chip_select_n_out)[*2])
    else $error("write hold too short");
  a_tick_align: assert property (
    $changed({address_latch_strobe_out, chip_select_n_out, write_strobe_n_out, read_strobe_n_out}) |-> bus_tick_out)
    else $error("pin change off bus cycle");
  a_recov_gap: assert property ($rose(chip_select_n_out) |-> (!done_out)[*2])
    else $error("recovery too short");
  a_done_end: assert property (done_out |-> !busy_out && chip_select_n_out ##1 !done_out)
    else $error("done pulse wrong");
  a_accept: assert property (start_in && !busy_out |=> busy_out)
    else $error("request not taken");
endmodule // meb_master_chk
bind meb_master meb_master_chk u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
  .busy_out(busy_out), .done_out(done_out), .ad_oe_out(ad_oe_out), .address_latch_strobe_out(address_latch_strobe_out),
  .chip_select_n_out(chip_select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .read_strobe_n_out(read_strobe_n_out), .bus_tick_out(bus_tick_out));

// File: sim/meb_periph.sv
/* Peripheral model on the shared lines.
   Assumes the master floats the lines while its read strobe is low. */
`timescale 1ns/100ps
module meb_periph (
  input wire sys_clk_in,
  input wire read_strobe_n_in,
  input wire [15:0] rd_data_in,
  output logic [15:0] ad_out = 16'h0
);
  // Released lines toggle, so a stale copy never passes for data
  always @(posedge sys_clk_in) begin
    ad_out <= !read_strobe_n_in ? rd_data_in : ~ad_out;
  end
endmodule // meb_periph

// File: sim/tb_muxed_expansion_bus_timing.sv
/* Bench: random accesses, phase lengths counted at the pins.
   Assumes a bus divider of 2 and the peripheral model. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_muxed_expansion_bus_timing;
  localparam int D = 2;
  logic sys_clk = 0, rst_n = 0, start = 0, wr = 0;
  logic [15:0] addr = 0, wd = 0, pd = 0, ad_in, ad, rdata;
  logic [1:0] la = 0, lc = 0, ls = 0, lh = 0;
  logic [3:0] lt = 0, lr = 0;
  wire oe, ale, cs_n, wr_n, rd_n, done, busy;
  int fail_count = 0, cmp_count = 0;
  logic [15:0] rd_q[$];
  meb_master #(.BUS_DIV(8'h2)) dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .start_in(start), .write_in(wr),
    .addr_in(addr), .wdata_in(wd), .address_phase_len_in(la), .cs_delay_len_in(lc),
    .data_setup_phase_len_in(ls), .strobe_phase_len_in(lt), .hold_phase_len_in(lh),
    .recovery_phase_len_in(lr), .ad_in(ad_in), .ad_out(ad), .ad_oe_out(oe),
    .address_latch_strobe_out(ale), .chip_select_n_out(cs_n), .write_strobe_n_out(wr_n),
    .read_strobe_n_out(rd_n), .bus_tick_out(), .busy_out(busy), .done_out(done), .rdata_out(rdata));
  meb_periph per (.sys_clk_in(sys_clk), .read_strobe_n_in(rd_n), .rd_data_in(pd), .ad_out(ad_in));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task stop_test;
    begin
      $display("Checks %0d, errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Worst access is near 95 cycles; the span leaves ample margin
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic acc(input int m);
    int na, nc, ns, nt, nh, nr, k;
    logic sc, st, sb;
    logic [15:0] ex;
    logic [63:0] r;
    begin
      @(posedge sys_clk);
      #1;
      r = {$urandom, $urandom};
      {wr, addr, wd, pd} = r[48:0];
      {la, lc, ls, lh, lt, lr} = m == 0 ? 16'h0 : m == 1 ? 16'hffff : 16'($urandom);
      if (!wr) rd_q.push_back(pd);
      start = 1;
      @(posedge sys_clk);
      #1;
      start = 0;
      {na, nc, ns, nt, nh, nr} = 0;
      {sc, st} = 2'h0;
      for (k = 0; k < 300 && done !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
        sb = wr ? wr_n : rd_n;
        if (ale === 1'b1) begin
          if (na == 0) `CHK("addr", addr, ad)
          na++;
        end else if (na > 0) begin
          if (ns == 0 && !st) `CHK("addr_hold", addr, ad)
          if (!sc && cs_n !== 1'b0) nc++;
          if (cs_n === 1'b0) sc = 1;
          if (sb === 1'b0) begin
            st = 1;
            nt++;
            if (wr) `CHK("wdata", wd, ad)
          end else if (!st) begin
            if (wr && ns == D) `CHK("wsetup", wd, ad)
            ns++;
          end else if (cs_n === 1'b0) begin
            nh++;
            if (wr) `CHK("whold", wd, ad)
          end else if (done !== 1'b1) nr++;
        end
      end
      `CHK("done", 1'b1, done)
      `CHK("ale_len", D * (la + 1), na)
      `CHK("cs_dly", D * (lc + 1), nc)
      `CHK("setup", D * ((ls > lc ? ls : lc) + 2), ns)
      `CHK("strobe", D * (lt + 1), nt)
      `CHK("hold", D * (lh + 1), nh)
      `CHK("recov", D * (lr + 1), nr)
      if (!wr) begin
        ex = rd_q.pop_front();
        `CHK("rdata", ex, rdata)
      end
    end
  endtask
  initial begin
    void'($urandom(32'h96f693d8));
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1;
    acc(0);
    acc(1);
    for (int i = 0; i < 40; i++) acc(2);
    stop_test;
  end
endmodule // tb_muxed_expansion_bus_timing
